// ===== eac_ctrl.sv
// Data EEPROM access controller: address, data and control registers,
// guarded program sequence, CPU stall and ready signalling.
// Assumes the CPU I/O bus strobes are one-cycle pulses synchronous to clk, and that
// osc_tick is a one-cycle pulse per period of the 8 MHz programming oscillator.
`timescale 1ns/1ps
// Operation
// - Linear 8-bit address, locations 0 to 255
// - Data register feeds writes, holds read byte
// - Mode field selects atomic, erase or write
// - Mode writes ignored while programming busy
// - Reset clears mode unless programming busy
// - Ready interrupt when enabled and global enable
// - Master enable self-clears after four cycles
// - Program enable only within master window
// - Programming start stalls CPU two cycles
// - Busy flag set until programming time elapses
// - Busy blocks flash programming via flash_prog_block
// - Read strobe fetches byte, stalls four cycles
// - Busy refuses reads and address changes
// - Control bits 7 and 6 read zero
// - Running programming survives a reset
// - Program time counted on oscillator ticks
module eac_ctrl #(
    parameter int ATOMIC_TICKS = eac_pkg::EAC_ATOMIC_TICKS,
    parameter int SPLIT_TICKS  = eac_pkg::EAC_SPLIT_TICKS
) (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       srst,
    // CPU I/O register bus
    input  wire logic [5:0] io_addr,
    input  wire logic       io_wr,
    input  wire logic       io_rd,
    input  wire logic [7:0] io_wdata,
    output logic      [7:0] io_rdata,
    // Programming oscillator tick
    input  wire logic       osc_tick,
    // CPU status
    input  wire logic       global_irq_en,
    output logic            cpu_stall,
    output logic            ready_irq,
    output logic            flash_prog_block
);
    // Timer width, kept local so the declarations below can be sized by it
    localparam int EAC_TIMER_W_L = eac_pkg::EAC_TIMER_W;

    // Register state
    logic [7:0]             nvm_addr_reg;       // Address register
    logic [7:0]             nvm_data_reg;       // Data register
    logic [1:0]             prog_mode_field;    // Programming mode
    logic                   ready_irq_enable;   // Ready interrupt enable
    logic                   master_prog_enable; // Master program enable
    logic                   prog_enable_busy;   // Program enable / busy
    logic [2:0]             mpe_cnt_reg;        // Master enable lifetime
    logic [2:0]             stall_cnt_reg;      // CPU stall countdown
    logic [EAC_TIMER_W_L-1:0] timer_reg;        // Oscillator ticks left
    logic [7:0]             prog_data_reg;      // Byte latched at start
    logic                   rd_pend_reg;        // Array read in flight
    logic [7:0]             io_rdata_reg;       // Registered bus read data
    logic [7:0]             array_q;            // Array read data

    // Bus decode
    wire ctrl_wr  = io_wr && (io_addr == eac_pkg::EAC_OFS_CONTROL);
    wire data_wr  = io_wr && (io_addr == eac_pkg::EAC_OFS_DATA);
    wire addr_wr  = io_wr && (io_addr == eac_pkg::EAC_OFS_ADDR);
    wire [7:0] ctrl_view = {2'h0, prog_mode_field, ready_irq_enable,
                            master_prog_enable, prog_enable_busy, 1'b0};
    wire [7:0] rd_mux = (io_addr == eac_pkg::EAC_OFS_CONTROL) ? ctrl_view :
                        (io_addr == eac_pkg::EAC_OFS_DATA)    ? nvm_data_reg :
                        (io_addr == eac_pkg::EAC_OFS_ADDR)    ? nvm_addr_reg : 8'h00;

    // Sequence decode
    wire mode_ok    = (prog_mode_field != 2'(eac_pkg::EAC_PM_RESERVED));
    wire prog_start = ctrl_wr && io_wdata[eac_pkg::EAC_BIT_PE] && master_prog_enable
                      && !prog_enable_busy && mode_ok && !srst;
    wire rd_start   = ctrl_wr && io_wdata[eac_pkg::EAC_BIT_READ]
                      && !prog_enable_busy && !srst;
    wire mpe_set    = ctrl_wr && io_wdata[eac_pkg::EAC_BIT_MPE] && !master_prog_enable;
    wire prog_done  = prog_enable_busy && osc_tick && (timer_reg == EAC_TIMER_W_L'(1));
    wire [EAC_TIMER_W_L-1:0] prog_ticks =
        (prog_mode_field == 2'(eac_pkg::EAC_PM_ATOMIC)) ? EAC_TIMER_W_L'(ATOMIC_TICKS)
                                                         : EAC_TIMER_W_L'(SPLIT_TICKS);
    wire erase_op   = (prog_mode_field == 2'(eac_pkg::EAC_PM_ERASE));
    wire wronly_op  = (prog_mode_field == 2'(eac_pkg::EAC_PM_WRITE));
    wire [7:0] array_wdata = erase_op ? eac_pkg::EAC_ERASED : prog_data_reg;

    // Storage array, written when the programming time has run out
    eac_array #(
        .DEPTH  (256),
        .ADDR_W (8)
    ) u_array (
        .clk     (clk),
        .wr_en   (prog_done),
        .wr_and  (wronly_op),
        .wr_addr (nvm_addr_reg),
        .wr_data (array_wdata),
        .rd_addr (nvm_addr_reg),
        .rd_data (array_q)
    );

    // Programming engine; the busy branch is tested first so that a reset cannot cut a
    // running operation short and leave a cell half programmed
    always_ff @(posedge clk)
    begin
        if (prog_enable_busy)
        begin
            // Time runs on oscillator ticks only, whatever the system clock rate
            if (prog_done)
            begin
                prog_enable_busy <= 1'b0;
            end
            else if (osc_tick)
            begin
                timer_reg <= timer_reg - EAC_TIMER_W_L'(1);
            end
        end
        else if (srst)
        begin
            // Idle reset; also settles the unknown power-up state of the flag
            prog_enable_busy <= 1'b0;
            timer_reg        <= '0;
        end
        else if (prog_start)
        begin
            prog_enable_busy <= 1'b1;
            timer_reg        <= prog_ticks;
            prog_data_reg    <= nvm_data_reg;
        end
    end

    // Mode field and address: held while busy, even across reset
    always_ff @(posedge clk)
    begin
        if (srst && !prog_enable_busy)
        begin
            prog_mode_field <= 2'(eac_pkg::EAC_PM_ATOMIC);
            nvm_addr_reg    <= eac_pkg::EAC_ADDR_RST;
        end
        else if (!prog_enable_busy)
        begin
            if (ctrl_wr)
            begin
                prog_mode_field <= io_wdata[eac_pkg::EAC_PM_HI:eac_pkg::EAC_PM_LO];
            end
            if (addr_wr)
            begin
                nvm_addr_reg <= io_wdata;
            end
        end
    end

    // Data register: software write, or array byte one cycle after a read strobe
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            nvm_data_reg <= eac_pkg::EAC_DATA_RST;
            rd_pend_reg  <= 1'b0;
        end
        else
        begin
            rd_pend_reg <= rd_start;
            if (rd_pend_reg)
            begin
                nvm_data_reg <= array_q;
            end
            else if (data_wr)
            begin
                nvm_data_reg <= io_wdata;
            end
        end
    end

    // Interrupt enable and master enable window
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            ready_irq_enable   <= 1'b0;
            master_prog_enable <= 1'b0;
            mpe_cnt_reg        <= 3'h0;
        end
        else
        begin
            if (ctrl_wr)
            begin
                ready_irq_enable <= io_wdata[eac_pkg::EAC_BIT_RIE];
            end
            if (mpe_set)
            begin
                master_prog_enable <= 1'b1;
                mpe_cnt_reg        <= eac_pkg::EAC_MPE_HOLD - 3'h1;
            end
            else if (master_prog_enable)
            begin
                // Rewriting the bit inside the window does not stretch it
                if (mpe_cnt_reg == 3'h0)
                begin
                    master_prog_enable <= 1'b0;
                end
                else
                begin
                    mpe_cnt_reg <= mpe_cnt_reg - 3'h1;
                end
            end
        end
    end

    // CPU stall countdown and registered bus read data
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            stall_cnt_reg <= 3'h0;
            io_rdata_reg  <= 8'h00;
        end
        else
        begin
            if (prog_start)
            begin
                stall_cnt_reg <= eac_pkg::EAC_PROG_STALL;
            end
            else if (rd_start)
            begin
                stall_cnt_reg <= eac_pkg::EAC_READ_STALL;
            end
            else if (stall_cnt_reg != 3'h0)
            begin
                stall_cnt_reg <= stall_cnt_reg - 3'h1;
            end
            io_rdata_reg <= io_rd ? rd_mux : 8'h00;
        end
    end

    // Outputs
    assign io_rdata         = io_rdata_reg;
    assign cpu_stall        = (stall_cnt_reg != 3'h0);
    assign ready_irq        = ready_irq_enable && global_irq_en && !prog_enable_busy;
    assign flash_prog_block = prog_enable_busy;

    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    property p_mpe_window;
        $rose(master_prog_enable) |-> master_prog_enable[*4] ##1 !master_prog_enable;
    endproperty
    a_mpe_window: assert property (p_mpe_window) else $error("master enable window not four cycles");

    property p_prog_stall;
        prog_start |=> cpu_stall[*2] ##1 !cpu_stall;
    endproperty
    a_prog_stall: assert property (p_prog_stall) else $error("program stall not two cycles");

    property p_read_stall;
        rd_start |=> cpu_stall[*4] ##1 !cpu_stall;
    endproperty
    a_read_stall: assert property (p_read_stall) else $error("read stall not four cycles");

    property p_pm_locked;
        prog_enable_busy && ctrl_wr |=> $stable(prog_mode_field);
    endproperty
    a_pm_locked: assert property (p_pm_locked) else $error("mode changed while busy");

    property p_addr_locked;
        prog_enable_busy && addr_wr |=> $stable(nvm_addr_reg);
    endproperty
    a_addr_locked: assert property (p_addr_locked) else $error("address changed while busy");

    property p_no_start_wo_mpe;
        ctrl_wr && io_wdata[1] && !master_prog_enable && !prog_enable_busy |=> !prog_enable_busy;
    endproperty
    a_no_start_wo_mpe: assert property (p_no_start_wo_mpe) else $error("start without master enable");

    property p_busy_blocks;
        prog_start |=> prog_enable_busy && flash_prog_block && !ready_irq;
    endproperty
    a_busy_blocks: assert property (p_busy_blocks) else $error("busy not flagged after start");

    property p_reserved_zero;
        io_rd && (io_addr == eac_pkg::EAC_OFS_CONTROL) |=> io_rdata[7:6] == 2'h0;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits not zero");

    property p_read_data;
        rd_start |=> ##1 nvm_data_reg == $past(array_q);
    endproperty
    a_read_data: assert property (p_read_data) else $error("read byte not loaded");

    property p_busy_release;
        prog_done |=> !prog_enable_busy && !flash_prog_block;
    endproperty
    a_busy_release: assert property (p_busy_release) else $error("busy not cleared at end of programming");

    // Must stay armed through srst, since reset is exactly what it watches
    property p_busy_through_reset;
        disable iff (1'b0) srst && prog_enable_busy && !prog_done |=> prog_enable_busy;
    endproperty
    a_busy_through_reset: assert property (p_busy_through_reset) else $error("reset cut programming short");

    c_prog: cover property (prog_start ##[1:300] prog_enable_busy);
    c_read: cover property (rd_start ##2 !cpu_stall);
    c_irq:  cover property ($rose(ready_irq));
    c_rst_busy: cover property (disable iff (1'b0) srst && prog_enable_busy);

endmodule : eac_ctrl

// ===== eac_pkg.sv
// Constants shared by the data EEPROM access controller and its testbench.
// Assumes an 8-bit I/O register bus and a 50 MHz system clock.
package eac_pkg;

    // I/O space offsets of the access registers
    localparam logic [5:0] EAC_OFS_CONTROL = 6'h1C;
    localparam logic [5:0] EAC_OFS_DATA    = 6'h1D;
    localparam logic [5:0] EAC_OFS_ADDR    = 6'h1E;

    // Control register field positions
    localparam int EAC_BIT_READ   = 0;
    localparam int EAC_BIT_PE     = 1;
    localparam int EAC_BIT_MPE    = 2;
    localparam int EAC_BIT_RIE    = 3;
    localparam int EAC_PM_LO      = 4;
    localparam int EAC_PM_HI      = 5;

    // Reset values and the erased cell value
    localparam logic [7:0] EAC_DATA_RST = 8'h00;
    localparam logic [7:0] EAC_ADDR_RST = 8'h00;
    localparam logic [7:0] EAC_ERASED   = 8'hFF;

    // Programming modes
    typedef enum logic [1:0] {
        EAC_PM_ATOMIC   = 2'b00,
        EAC_PM_ERASE    = 2'b01,
        EAC_PM_WRITE    = 2'b10,
        EAC_PM_RESERVED = 2'b11
    } eac_pm_t;

    // Timing: system clock and programming oscillator
    localparam int EAC_CLK_MHZ       = 50;
    localparam int EAC_OSC_KHZ       = 8000;
    localparam int EAC_ATOMIC_US     = 3400;
    localparam int EAC_SPLIT_US      = 1800;
    localparam int EAC_ATOMIC_TICKS  = EAC_ATOMIC_US * EAC_OSC_KHZ / 1000;
    localparam int EAC_SPLIT_TICKS   = EAC_SPLIT_US * EAC_OSC_KHZ / 1000;
    localparam int EAC_TIMER_W       = 16;

    // CPU-side cycle figures
    localparam logic [2:0] EAC_MPE_HOLD    = 3'h4;
    localparam logic [2:0] EAC_PROG_STALL  = 3'h2;
    localparam logic [2:0] EAC_READ_STALL  = 3'h4;

endpackage : eac_pkg

// ===== eac_array.sv
// Byte-wide storage array for the data EEPROM with a registered read port.
// Assumes a single clock; the write port may erase, overwrite or clear bits.
`timescale 1ns/1ps
module eac_array #(
    parameter int DEPTH  = 256,
    parameter int ADDR_W = 8
) (
    // Clock
    input  wire logic              clk,
    // Write port
    input  wire logic              wr_en,
    input  wire logic              wr_and,
    input  wire logic [ADDR_W-1:0] wr_addr,
    input  wire logic [7:0]        wr_data,
    // Read port
    input  wire logic [ADDR_W-1:0] rd_addr,
    output logic      [7:0]        rd_data
);
    // Cell contents, never reset: they model non-volatile storage
    logic [7:0] cells [DEPTH];

    // Write-only mode can only pull bits low, as a real cell would
    always_ff @(posedge clk)
    begin
        if (wr_en)
        begin
            cells[wr_addr] <= wr_and ? (cells[wr_addr] & wr_data) : wr_data;
        end
        rd_data <= cells[rd_addr];
    end

endmodule : eac_array

// ===== eac_osc_model.sv
// Model of the programming oscillator that times EEPROM programming.
// Assumes one system clock; emits a one-cycle tick every DIV clocks.
`timescale 1ns/1ps
module eac_osc_model #(
    parameter int DIV = 6
) (
    // Clock
    input  wire logic clk,
    // Tick to the controller
    output logic      osc_tick
);
    // Free running divider; near 8 MHz from 50 MHz, exact rate is not needed
    int unsigned cnt_reg = 0;

    // Tick lasts one clock per period; the oscillator runs free through reset
    always_ff @(posedge clk)
    begin
        cnt_reg  <= (cnt_reg == DIV - 1) ? 0 : cnt_reg + 1;
        osc_tick <= (cnt_reg == DIV - 1);
    end
endmodule : eac_osc_model

// ===== eac_ctrl_tb_top.sv
// Self-checking bench for the EEPROM access controller.
// Assumes short programming counts so each operation takes a few dozen clocks.
`timescale 1ns/1ps
module eac_ctrl_tb_top;
    localparam logic [5:0] C = eac_pkg::EAC_OFS_CONTROL;
    localparam logic [5:0] D = eac_pkg::EAC_OFS_DATA;
    localparam logic [5:0] A = eac_pkg::EAC_OFS_ADDR;

    // Clock, reset and bus
    logic       clk           = 1'b0;
    logic       srst          = 1'b1;
    logic [5:0] io_addr       = 6'h00;
    logic       io_wr         = 1'b0;
    logic       io_rd         = 1'b0;
    logic [7:0] io_wdata      = 8'h00;
    logic       global_irq_en = 1'b1;
    // Design outputs
    logic [7:0] io_rdata;
    logic       osc_tick;
    logic       cpu_stall;
    logic       ready_irq;
    logic       flash_prog_block;
    // Scratch and counters
    logic [7:0] v;
    int         n;
    int         error_cnt     = 0;
    int         total_checks  = 0;

    always #10 clk = ~clk;

    // Small counts keep each programming pass short
    eac_ctrl #(.ATOMIC_TICKS(5), .SPLIT_TICKS(3)) uut (
        .clk(clk), .srst(srst), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
        .io_wdata(io_wdata), .io_rdata(io_rdata), .osc_tick(osc_tick),
        .global_irq_en(global_irq_en), .cpu_stall(cpu_stall), .ready_irq(ready_irq),
        .flash_prog_block(flash_prog_block));

    eac_osc_model #(.DIV(6)) osc (.clk(clk), .osc_tick(osc_tick));

    // Compare and count
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask : chk

    // One bus write; strobe stands for exactly one taking edge
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(posedge clk);
        #1 io_addr = a; io_wdata = d; io_wr = 1'b1;
        @(posedge clk);
        #1 io_wr = 1'b0; io_wdata = 8'h00;
    endtask : wr

    // One bus read; data is taken in the cycle after the strobe edge
    task automatic rd(input logic [5:0] a, output logic [7:0] d);
        @(posedge clk);
        #1 io_addr = a; io_rd = 1'b1;
        @(posedge clk);
        #1 d = io_rdata; io_rd = 1'b0;
    endtask : rd

    // Count stalled cycles from now over eight cycles
    task automatic stalls(output int c);
        c = 0;
        for (int i = 0; i < 8; i++)
        begin
            if (cpu_stall === 1'b1) c++;
            @(posedge clk);
            #1;
        end
    endtask : stalls

    // Guarded program sequence: mode first, master enable, then start
    task automatic prog(input logic [7:0] m, output int c);
        wr(C, m);
        wr(C, m | 8'h04);
        wr(C, m | 8'h02);
        stalls(c);
    endtask : prog

    // Poll the busy flag before any further access, bounded
    task automatic wait_idle;
        int k;
        k = 0;
        while (flash_prog_block !== 1'b0 && k < 400)
        begin
            @(posedge clk);
            #1 k++;
        end
        chk({7'h00, flash_prog_block}, 8'h00);
    endtask : wait_idle

    // Fetch the byte at the held address through the read strobe
    task automatic fetch(output logic [7:0] d, output int c);
        wr(C, 8'h01);
        stalls(c);
        rd(D, d);
    endtask : fetch

    task automatic test_done;
        if (error_cnt == 0 && total_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : test_done

    // Cut a hang short
    initial
    begin
        #400000;
        error_cnt++;
        test_done();
    end

    // Main sequence
    initial
    begin
        repeat (3) @(posedge clk);
        #1 srst = 1'b0;
        rd(D, v); chk(v, 8'h00);
        rd(C, v); chk(v, 8'h00);
        rd(6'h3F, v); chk(v, 8'h00);
        // Atomic program at the top address with ready enable kept
        wr(A, 8'hFF);
        wr(D, 8'hA5);
        prog(8'h08, n); chk(n[7:0], 8'h02);
        chk({7'h00, flash_prog_block}, 8'h01);
        chk({7'h00, ready_irq}, 8'h00);
        rd(C, v); chk(v, 8'h0A);
        wr(A, 8'h05);
        wr(C, 8'hE8);
        rd(C, v); chk(v, 8'h0A);
        rd(A, v);
        chk(v, 8'hFF);
        wr(C, 8'h09);
        stalls(n); chk(n[7:0], 8'h00);
        wait_idle();
        chk({7'h00, ready_irq}, 8'h01);
        global_irq_en = 1'b0;
        #1 chk({7'h00, ready_irq}, 8'h00);
        @(posedge clk);
        #1 global_irq_en = 1'b1;
        wr(D, 8'h00);
        fetch(v, n); chk(n[7:0], 8'h04);
        chk(v, 8'hA5);
        chk({7'h00, ready_irq}, 8'h00);
        // Erase with a reset landing in mid-operation
        wr(C, 8'h10);
        prog(8'h10, n);
        @(posedge clk);
        #1 srst = 1'b1;
        @(posedge clk);
        #1 srst = 1'b0;
        chk({7'h00, flash_prog_block}, 8'h01);
        rd(C, v); chk(v, 8'h12);
        wait_idle();
        fetch(v, n); chk(v, 8'hFF);
        // Write only clears bits into the erased cell
        wr(D, 8'h3C);
        prog(8'h20, n);
        wait_idle();
        fetch(v, n); chk(v, 8'h3C);
        // Reserved mode never starts
        prog(8'h30, n); chk(n[7:0], 8'h00);
        chk({7'h00, flash_prog_block}, 8'h00);
        // Start without master enable, then after the window closed
        wr(C, 8'h02);
        chk({7'h00, flash_prog_block}, 8'h00);
        wr(C, 8'h04);
        rd(C, v); chk(v, 8'h04);
        repeat (3) @(posedge clk);
        #1 rd(C, v); chk(v, 8'h00);
        wr(C, 8'h02);
        chk({7'h00, flash_prog_block}, 8'h00);
        // Idle reset clears the control register
        wr(C, 8'h18);
        @(posedge clk);
        #1 srst = 1'b1;
        @(posedge clk);
        #1 srst = 1'b0;
        rd(C, v); chk(v, 8'h00);
        test_done();
    end
endmodule : eac_ctrl_tb_top
